// >>> bfi_pkg.sv
// Operation
// RULE1: fault lamp is lit while system reset is applied.
// RULE2: host commands the lamp on after each cpu reset, then runs diagnostics.
// RULE3: a failed diagnostic leaves the lamp lit or blinking, never off.
// RULE4: a passed diagnostic turns the fault lamp off.
// RULE5: one flash is processor failure, two flashes bus or exception error.
// RULE6: three flashes is memory test failure, four local watchdog timeout.
// RULE7: five flashes erasable memory failure, six flash program or erase failure.
// RULE8: seven flashes is kernel software watchdog count error.
// RULE9: ten flashes comms controller failure, eleven real time clock failure.
// RULE10: twelve flashes coprocessor memory failure; twenty and up reserved for os.
// RULE11: each of three serial ports is watched and its errors flagged.
// RULE12: software, hardware and bus watchdog expiry is a microcontroller fault.
// RULE13: a microcontroller fault forces every output into shutdown.
// RULE14: application may latch input faults beyond high or low thresholds.
// RULE15: bursts repeat with a pause clearly longer than the flash spacing.
`default_nettype none
package bfi_pkg;
   localparam int unsigned CLK_HZ       = 10_000_000;
   localparam int unsigned CYC_PER_MS   = CLK_HZ / 1000;
   localparam int unsigned FLASH_ON_MS  = 250;
   localparam int unsigned FLASH_OFF_MS = 250;
   localparam int unsigned BURST_GAP_MS = 1500;
   localparam int unsigned WD_SW_MS     = 100;
   localparam int unsigned WD_HW_MS     = 50;
   localparam int unsigned WD_BUS_MS    = 200;
   localparam int unsigned FLASH_ON_CYC  = FLASH_ON_MS * CYC_PER_MS;
   localparam int unsigned FLASH_OFF_CYC = FLASH_OFF_MS * CYC_PER_MS;
   localparam int unsigned BURST_GAP_CYC = BURST_GAP_MS * CYC_PER_MS;
   localparam int unsigned WD_SW_CYC     = WD_SW_MS * CYC_PER_MS;
   localparam int unsigned WD_HW_CYC     = WD_HW_MS * CYC_PER_MS;
   localparam int unsigned WD_BUS_CYC    = WD_BUS_MS * CYC_PER_MS;
   localparam int unsigned CODE_W   = 5;
   localparam int unsigned NSER     = 3;
   localparam int unsigned NWD      = 3;
   localparam int unsigned WD_SW    = 0;
   localparam int unsigned WD_HW    = 1;
   localparam int unsigned WD_BUS   = 2;
   localparam logic [4:0] CODE_STEADY = 5'h00;
   localparam logic [4:0] CODE_CPU    = 5'h01;
   localparam logic [4:0] CODE_BUS    = 5'h02;
   localparam logic [4:0] CODE_RAM    = 5'h03;
   localparam logic [4:0] CODE_LWD    = 5'h04;
   localparam logic [4:0] CODE_EE     = 5'h05;
   localparam logic [4:0] CODE_FLASH  = 5'h06;
   localparam logic [4:0] CODE_KWD    = 5'h07;
   localparam logic [4:0] CODE_COMM   = 5'h0A;
   localparam logic [4:0] CODE_RTC    = 5'h0B;
   localparam logic [4:0] CODE_COPMEM = 5'h0C;
   localparam logic [4:0] CODE_OS_MIN = 5'h14;
   typedef enum logic [1:0] {ST_BOOT, ST_TEST, ST_PASS, ST_FAIL} bfi_state_t;
   typedef enum logic [1:0] {BL_IDLE, BL_ON, BL_OFF, BL_GAP} bfi_blink_t;

   // unlisted codes fall back to a steady lamp rather than a misleading count
   function automatic logic bfi_code_ok(input logic [4:0] c);
      bfi_code_ok = (c >= CODE_CPU && c <= CODE_KWD)     // see RULE5 RULE6 RULE7 RULE8
                 || (c >= CODE_COMM && c <= CODE_COPMEM) // see RULE9 RULE10
                 || (c >= CODE_OS_MIN);                  // see RULE10
   endfunction
endpackage
`default_nettype wire

// >>> bfi_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
module bfi_watchdog
   import bfi_pkg::*;
#(
   parameter int unsigned TIMEOUT = 1000
)
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic arm,
   input  wire logic kick,
   output var  logic expired
);
   logic [31:0] cnt;

   // expiry is sticky until reset: a late kick must not revive the board
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt <= 32'h0;
      else if (!arm || kick)
         cnt <= 32'h0;
      else if (cnt < TIMEOUT)
         cnt <= cnt + 32'h1;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         expired <= 1'b0;
      else if (arm && !kick && cnt == TIMEOUT - 1)
         expired <= 1'b1; // see RULE12
   end

   property p_wd_sticky;
      @(posedge clk) disable iff (!rst_n)
      expired |=> expired;
   endproperty
   a_wd_sticky: assert property (p_wd_sticky) else $error("watchdog expiry dropped"); // see RULE12
endmodule
`default_nettype wire

// >>> bfi_blinker.sv
`timescale 1ns/1ps
`default_nettype none
module bfi_blinker
   import bfi_pkg::*;
#(
   parameter int unsigned ON_CYC  = FLASH_ON_CYC,
   parameter int unsigned OFF_CYC = FLASH_OFF_CYC,
   parameter int unsigned GAP_CYC = BURST_GAP_CYC
)
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        run,
   input  wire logic [4:0]  code,
   output var  logic        blink
);
   bfi_blink_t  phase;
   logic [31:0] tmr;
   logic [4:0]  flashes;
   logic [31:0] off_run;

   // code is not latched between bursts; it is compared live at the end of each flash
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         phase   <= BL_IDLE;
         tmr     <= 32'h0;
         flashes <= 5'h00;
      end
      else if (!run)
      begin
         phase   <= BL_IDLE;
         tmr     <= 32'h0;
         flashes <= 5'h00;
      end
      else
      begin
         case (phase)
            BL_IDLE:
            begin
               phase   <= BL_ON;
               tmr     <= 32'h0;
               flashes <= 5'h01;
            end
            BL_ON:
               if (tmr == ON_CYC - 1)
               begin
                  tmr   <= 32'h0;
                  phase <= (flashes >= code) ? BL_GAP : BL_OFF; // see RULE15
               end
               else
                  tmr <= tmr + 32'h1;
            BL_OFF:
               if (tmr == OFF_CYC - 1)
               begin
                  tmr     <= 32'h0;
                  phase   <= BL_ON;
                  flashes <= flashes + 5'h01;
               end
               else
                  tmr <= tmr + 32'h1;
            default:
               if (tmr == GAP_CYC - 1)
               begin
                  tmr     <= 32'h0;
                  phase   <= BL_ON; // see RULE15
                  flashes <= 5'h01;
               end
               else
                  tmr <= tmr + 32'h1;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         blink <= 1'b0;
      else
         blink <= run && (phase == BL_ON);
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         off_run <= 32'h0;
      else if (blink)
         off_run <= 32'h0;
      else
         off_run <= off_run + 32'h1;
   end

   // the first flash after run rises has no spacing in front of it to measure
   property p_spacing;
      @(posedge clk) disable iff (!rst_n)
      ($rose(blink) && $past(run, 3)) |-> (off_run == OFF_CYC || off_run == GAP_CYC);
   endproperty
   a_spacing: assert property (p_spacing) else $error("flash spacing wrong"); // see RULE15
endmodule
`default_nettype wire

// >>> bfi_top.sv
`timescale 1ns/1ps
`default_nettype none
module bfi_top
   import bfi_pkg::*;
#(
   parameter int unsigned ON_CYC     = FLASH_ON_CYC,
   parameter int unsigned OFF_CYC    = FLASH_OFF_CYC,
   parameter int unsigned GAP_CYC    = BURST_GAP_CYC,
   parameter int unsigned SW_WD_CYC  = WD_SW_CYC,
   parameter int unsigned HW_WD_CYC  = WD_HW_CYC,
   parameter int unsigned BUS_WD_CYC = WD_BUS_CYC
)
(
   input  wire logic            sys_clk,
   input  wire logic            nrst,
   input  wire logic            lamp_on_cmd,
   input  wire logic            diag_pass,
   input  wire logic            diag_fail,
   input  wire logic [4:0]      fail_code,
   input  wire logic            sw_wd_kick,
   input  wire logic            hw_wd_kick,
   input  wire logic            bus_wd_kick,
   input  wire logic [NSER-1:0] ser_frame_err,
   input  wire logic [NSER-1:0] ser_parity_err,
   input  wire logic [NSER-1:0] ser_overrun_err,
   input  wire logic [NSER-1:0] ser_err_clr,
   output var  logic            fault_lamp,
   output var  logic [4:0]      blink_code,
   output var  logic            diag_passed,
   output var  logic [NWD-1:0]  wd_expired,
   output var  logic            mcu_fault,
   output var  logic            out_shutdown,
   output var  logic [NSER-1:0] ser_err_flag
);
   logic            rst_meta;
   logic            rst_n;
   bfi_state_t      state;
   logic            wd_arm;
   logic [NWD-1:0]  wd_exp;
   logic            wd_any;
   logic            blink;
   logic            run_blink;
   logic [NSER-1:0] ser_hit;
   logic [4:0]      next_code;

   // release is synchronised; assertion is still immediate
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   assign wd_any    = |wd_exp;
   assign run_blink = (state == ST_FAIL) && (blink_code != CODE_STEADY);
   assign ser_hit   = ser_frame_err | ser_parity_err | ser_overrun_err;

   // board-detected watchdog faults outrank a host-reported code
   always_comb
   begin
      if (wd_exp[WD_HW])
         next_code = CODE_LWD; // see RULE6
      else if (wd_exp[WD_SW])
         next_code = CODE_KWD; // see RULE8
      else if (wd_exp[WD_BUS])
         next_code = CODE_STEADY;
      else if (bfi_code_ok(fail_code))
         next_code = fail_code; // see RULE5 RULE7 RULE9 RULE10
      else
         next_code = CODE_STEADY;
   end

   // lamp stays lit from boot through the host's init and test sequence
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         state <= ST_BOOT; // see RULE1
      else if (wd_any && state != ST_FAIL)
         state <= ST_FAIL; // see RULE12
      else
      begin
         case (state)
            ST_BOOT:
               if (lamp_on_cmd)
                  state <= ST_TEST; // see RULE2
            ST_TEST:
               if (diag_fail)
                  state <= ST_FAIL; // see RULE3
               else if (diag_pass)
                  state <= ST_PASS; // see RULE4
            ST_PASS:
               if (lamp_on_cmd)
                  state <= ST_TEST;
               else if (diag_fail)
                  state <= ST_FAIL;
            default:
               if (lamp_on_cmd && !mcu_fault && !wd_any)
                  state <= ST_TEST; // see RULE3
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         blink_code <= CODE_STEADY;
      else if (wd_any && state != ST_FAIL)
         blink_code <= next_code;
      else if (diag_fail && (state == ST_TEST || state == ST_PASS))
         blink_code <= next_code;
      else if (state != ST_FAIL)
         blink_code <= CODE_STEADY;
   end

   // watchdogs run only once the board has passed; during test nobody kicks
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         wd_arm <= 1'b0;
      else if (state == ST_PASS)
         wd_arm <= 1'b1;
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         diag_passed <= 1'b0;
      else
         diag_passed <= (state == ST_PASS);
   end

   bfi_watchdog #(.TIMEOUT(SW_WD_CYC)) u_wd_sw
   (
      .clk     (sys_clk),
      .rst_n   (rst_n),
      .arm     (wd_arm),
      .kick    (sw_wd_kick),
      .expired (wd_exp[WD_SW])
   );

   bfi_watchdog #(.TIMEOUT(HW_WD_CYC)) u_wd_hw
   (
      .clk     (sys_clk),
      .rst_n   (rst_n),
      .arm     (wd_arm),
      .kick    (hw_wd_kick),
      .expired (wd_exp[WD_HW])
   );

   bfi_watchdog #(.TIMEOUT(BUS_WD_CYC)) u_wd_bus
   (
      .clk     (sys_clk),
      .rst_n   (rst_n),
      .arm     (wd_arm),
      .kick    (bus_wd_kick),
      .expired (wd_exp[WD_BUS])
   );

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         wd_expired <= '0;
      else
         wd_expired <= wd_exp;
   end

   // fault is latched until reset; outputs must not chatter back on
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         mcu_fault <= 1'b0;
      else if (wd_any)
         mcu_fault <= 1'b1; // see RULE12
   end

   // shutdown also asserted during reset, the safe state for outputs
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         out_shutdown <= 1'b1;
      else
         out_shutdown <= mcu_fault || wd_any; // see RULE13
   end

   // set wins over clear so an error in the clear cycle is kept
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         ser_err_flag <= '0;
      else
         ser_err_flag <= (ser_err_flag & ~ser_err_clr) | ser_hit; // see RULE11
   end

   bfi_blinker #(.ON_CYC(ON_CYC), .OFF_CYC(OFF_CYC), .GAP_CYC(GAP_CYC)) u_blink
   (
      .clk   (sys_clk),
      .rst_n (rst_n),
      .run   (run_blink),
      .code  (blink_code),
      .blink (blink)
   );

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         fault_lamp <= 1'b1; // see RULE1
      else if (state == ST_PASS)
         fault_lamp <= 1'b0; // see RULE4
      else if (run_blink)
         fault_lamp <= blink; // see RULE3 RULE15
      else
         fault_lamp <= 1'b1; // see RULE3
   end

   sequence s_pass_clean;
      state == ST_TEST && diag_pass && !diag_fail && !wd_any;
   endsequence

   sequence s_fail_taken;
      state == ST_TEST && diag_fail && !wd_any;
   endsequence

   property p_boot_lamp;
      @(posedge sys_clk) disable iff (!rst_n)
      $rose(rst_n) |-> fault_lamp && state == ST_BOOT;
   endproperty
   a_boot_lamp: assert property (p_boot_lamp) else $error("lamp off at boot"); // see RULE1

   property p_lamp_until_pass;
      @(posedge sys_clk) disable iff (!rst_n)
      (state == ST_BOOT || state == ST_TEST) |=> fault_lamp;
   endproperty
   a_lamp_until_pass: assert property (p_lamp_until_pass) else $error("lamp off before pass"); // see RULE2

   property p_pass_off;
      @(posedge sys_clk) disable iff (!rst_n)
      s_pass_clean |=> state == ST_PASS ##1 !fault_lamp;
   endproperty
   a_pass_off: assert property (p_pass_off) else $error("pass did not clear lamp"); // see RULE4

   property p_fail_hold;
      @(posedge sys_clk) disable iff (!rst_n)
      s_fail_taken |=> state == ST_FAIL ##1 (fault_lamp || run_blink);
   endproperty
   a_fail_hold: assert property (p_fail_hold) else $error("fail cleared lamp"); // see RULE3

   property p_fail_no_pass;
      @(posedge sys_clk) disable iff (!rst_n)
      (state == ST_FAIL && diag_pass && !lamp_on_cmd) |=> state == ST_FAIL;
   endproperty
   a_fail_no_pass: assert property (p_fail_no_pass) else $error("pass left fail"); // see RULE3

   property p_code_taken;
      @(posedge sys_clk) disable iff (!rst_n)
      (s_fail_taken and (fail_code == CODE_RAM)) |=> blink_code == CODE_RAM;
   endproperty
   a_code_taken: assert property (p_code_taken) else $error("fail code lost"); // see RULE6

   property p_hw_wd_code;
      @(posedge sys_clk) disable iff (!rst_n)
      ($rose(wd_exp[WD_HW]) && state != ST_FAIL) |=> blink_code == CODE_LWD;
   endproperty
   a_hw_wd_code: assert property (p_hw_wd_code) else $error("watchdog code wrong"); // see RULE6

   property p_kwd_code;
      @(posedge sys_clk) disable iff (!rst_n)
      ($rose(wd_exp[WD_SW]) && !wd_exp[WD_HW] && state != ST_FAIL) |=> blink_code == CODE_KWD;
   endproperty
   a_kwd_code: assert property (p_kwd_code) else $error("kernel watchdog code wrong"); // see RULE8

   property p_ser_flag;
      @(posedge sys_clk) disable iff (!rst_n)
      (|ser_hit) |=> (ser_err_flag & $past(ser_hit)) == $past(ser_hit);
   endproperty
   a_ser_flag: assert property (p_ser_flag) else $error("serial error not flagged"); // see RULE11

   property p_wd_fault;
      @(posedge sys_clk) disable iff (!rst_n)
      wd_any |=> mcu_fault && state == ST_FAIL;
   endproperty
   a_wd_fault: assert property (p_wd_fault) else $error("watchdog not a fault"); // see RULE12

   property p_shutdown;
      @(posedge sys_clk) disable iff (!rst_n)
      $rose(wd_any) |=> out_shutdown [*2];
   endproperty
   a_shutdown: assert property (p_shutdown) else $error("outputs not shut down"); // see RULE13

   property p_fault_sticky;
      @(posedge sys_clk) disable iff (!rst_n)
      mcu_fault |=> mcu_fault && out_shutdown;
   endproperty
   a_fault_sticky: assert property (p_fault_sticky) else $error("fault released"); // see RULE13
endmodule
`default_nettype wire

// >>> bfi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module bfi_host_model
   import bfi_pkg::*;
(
   input  wire logic       clk,
   output var  logic       lamp_on_cmd,
   output var  logic       diag_pass,
   output var  logic       diag_fail,
   output wire logic [4:0] fail_code
);
   logic [4:0] code_q;
   logic [4:0] junk;
   // the code is only qualified by diag_fail, so it wanders otherwise
   assign fail_code = diag_fail ? code_q : junk;
   initial
   begin
      lamp_on_cmd = 1'b0;
      diag_pass = 1'b0;
      diag_fail = 1'b0;
      code_q = 5'h00;
      junk = 5'h00;
   end
   always @(negedge clk) junk <= junk + 5'h0B;
   task automatic init();
      @(negedge clk);
      lamp_on_cmd = 1'b1;
      @(negedge clk);
      lamp_on_cmd = 1'b0;
   endtask
   task automatic pass();
      @(negedge clk);
      diag_pass = 1'b1;
      @(negedge clk);
      diag_pass = 1'b0;
   endtask
   task automatic fail(input logic [4:0] c);
      @(negedge clk);
      code_q = c;
      diag_fail = 1'b1;
      @(negedge clk);
      diag_fail = 1'b0;
   endtask
endmodule
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
   import bfi_pkg::*;
();
   localparam int ON_C  = 4;
   localparam int OFF_C = 4;
   localparam int GAP_C = 20;
   localparam int SW_C  = 50;
   localparam int HW_C  = 30;
   localparam int BUS_C = 80;
   logic            sys_clk;
   logic            nrst;
   wire logic       lamp_on_cmd;
   wire logic       diag_pass;
   wire logic       diag_fail;
   wire logic [4:0] fail_code;
   logic [2:0]      kick;
   logic [2:0]      kick_en;
   logic [2:0]      fe;
   logic [2:0]      pe;
   logic [2:0]      oe;
   logic [2:0]      clr;
   logic            fault_lamp;
   logic [4:0]      blink_code;
   logic            diag_passed;
   logic [2:0]      wd_expired;
   logic            mcu_fault;
   logic            out_shutdown;
   logic [2:0]      ser_err_flag;
   int              miscompares;
   int              n_tests;
   int              cyc;

   bfi_host_model host (.clk(sys_clk), .lamp_on_cmd(lamp_on_cmd), .diag_pass(diag_pass),
      .diag_fail(diag_fail), .fail_code(fail_code));
   bfi_top #(.ON_CYC(ON_C), .OFF_CYC(OFF_C), .GAP_CYC(GAP_C), .SW_WD_CYC(SW_C),
      .HW_WD_CYC(HW_C), .BUS_WD_CYC(BUS_C)) dut (.sys_clk(sys_clk), .nrst(nrst),
      .lamp_on_cmd(lamp_on_cmd), .diag_pass(diag_pass), .diag_fail(diag_fail),
      .fail_code(fail_code), .sw_wd_kick(kick[WD_SW]), .hw_wd_kick(kick[WD_HW]),
      .bus_wd_kick(kick[WD_BUS]), .ser_frame_err(fe), .ser_parity_err(pe),
      .ser_overrun_err(oe), .ser_err_clr(clr), .fault_lamp(fault_lamp),
      .blink_code(blink_code), .diag_passed(diag_passed), .wd_expired(wd_expired),
      .mcu_fault(mcu_fault), .out_shutdown(out_shutdown), .ser_err_flag(ser_err_flag));

   always #50 sys_clk = ~sys_clk;
   // kick at random, often enough that an enabled watchdog never starves
   always @(negedge sys_clk) kick <= kick_en & 3'($urandom);
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         miscompares++;
         summarize();
      end
   end

   task automatic summarize();
      $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         miscompares++;
         $display("unexpected %s: expected %0h, seen %0h", nm, e, g);
      end
   endtask

   // codes outside the table show a steady lamp, i.e. no count
   function automatic int exp_flash(input logic [4:0] c);
      if ((c >= 5'h01 && c <= 5'h07) || (c >= 5'h0A && c <= 5'h0C) || c >= 5'h14)
         return int'(c);
      return 0;
   endfunction

   task automatic do_reset();
      @(negedge sys_clk);
      nrst = 1'b0;
      repeat (6) @(negedge sys_clk);
      chk("lamp in reset", 1, fault_lamp);
      chk("shutdown in reset", 1, out_shutdown);
      nrst = 1'b1;
      repeat (3) @(negedge sys_clk);
      chk("lamp after reset", 1, fault_lamp);
      chk("no shutdown", 0, out_shutdown);
   endtask

   task automatic show_code(input logic [4:0] c);
      int e;
      int n;
      int g;
      int low;
      e = exp_flash(c);
      n = 0;
      g = 0;
      low = 0;
      host.init();
      host.fail(c);
      repeat (2) @(negedge sys_clk);
      chk("blink_code", e, blink_code);
      host.pass();
      repeat (2) @(negedge sys_clk);
      chk("pass refused", 0, diag_passed);
      if (e == 0)
      begin
         repeat (40)
         begin
            @(negedge sys_clk);
            n += (fault_lamp !== 1'b1);
         end
         chk("steady lamp", 0, n);
         return;
      end
      // sync to a gap first so the count starts on a burst boundary
      while (low <= OFF_C + 1 && g < 700)
      begin
         @(negedge sys_clk);
         g++;
         low = fault_lamp ? 0 : low + 1;
      end
      while (fault_lamp !== 1'b1 && g < 700)
      begin
         @(negedge sys_clk);
         g++;
      end
      n = 1;
      low = 0;
      while (low <= OFF_C + 1 && g < 700)
      begin
         @(negedge sys_clk);
         g++;
         if (fault_lamp && low > 0)
            n++;
         low = fault_lamp ? 0 : low + 1;
      end
      while (fault_lamp !== 1'b1 && g < 700)
      begin
         @(negedge sys_clk);
         g++;
         low++;
      end
      chk("flashes", e, n);
      chk("gap long", 1, low >= GAP_C);
   endtask

   initial
   begin
      int k;
      int n;
      int t;
      logic [4:0] codes[$];
      sys_clk = 1'b0;
      nrst = 1'b0;
      kick_en = 3'h7;
      fe = 3'h0;
      pe = 3'h0;
      oe = 3'h0;
      clr = 3'h0;
      k = $urandom(87);
      do_reset();
      host.fail(CODE_CPU);
      @(negedge sys_clk);
      chk("fail before init", 0, blink_code);
      host.init();
      repeat (2) @(negedge sys_clk);
      chk("lamp after init", 1, fault_lamp);
      host.pass();
      repeat (3) @(negedge sys_clk);
      chk("lamp after pass", 0, fault_lamp);
      chk("passed", 1, diag_passed);
      codes = {CODE_CPU, CODE_BUS, CODE_RAM, CODE_LWD, CODE_EE, CODE_FLASH, CODE_KWD,
         CODE_COMM, CODE_RTC, CODE_COPMEM, CODE_OS_MIN, 5'h1F, 5'h08, 5'h0D};
      repeat (3) codes.push_back(5'($urandom_range(31, 0)));
      foreach (codes[i]) show_code(codes[i]);
      for (int p = 0; p < NSER; p++)
      begin
         k = $urandom_range(2, 0);
         @(negedge sys_clk);
         fe[p] = (k == 0);
         pe[p] = (k == 1);
         oe[p] = (k == 2);
         @(negedge sys_clk);
         fe = 3'h0;
         oe = 3'h0;
         pe = 3'h0;
         chk("ser flag set", 1 << p, ser_err_flag);
         clr[p] = 1'b1;
         pe[p] = 1'b1;
         @(negedge sys_clk);
         pe = 3'h0;
         chk("set beats clear", 1 << p, ser_err_flag);
         @(negedge sys_clk);
         clr = 3'h0;
         chk("ser flag clear", 0, ser_err_flag);
      end
      for (int i = 0; i < NWD; i++)
      begin
         t = (i == WD_SW) ? SW_C : (i == WD_HW) ? HW_C : BUS_C;
         do_reset();
         host.init();
         kick_en = 3'h7 & ~(3'h1 << i);
         host.pass();
         n = 0;
         while (mcu_fault !== 1'b1 && n < 200)
         begin
            @(negedge sys_clk);
            n++;
         end
         chk("wd delay ok", 1, n >= t - 3 && n <= t + 4);
         repeat (3) @(negedge sys_clk);
         chk("wd_expired", 1 << i, wd_expired);
         chk("shutdown", 1, out_shutdown);
         k = (i == WD_SW) ? 7 : (i == WD_HW) ? 4 : 0;
         chk("wd code", k, blink_code);
         host.init();
         repeat (3) @(negedge sys_clk);
         chk("shutdown held", 1, out_shutdown);
         chk("code held", k, blink_code);
         kick_en = 3'h7;
      end
      summarize();
   end
endmodule
`default_nettype wire
